// *** hdl/bvs_defs.vh ***
`ifndef BVS_DEFS_VH
`define BVS_DEFS_VH
// command code of the boot voltage register
`define BVS_CMD_CODE 8'hD5
// field layout
`define BVS_CODE_MSB 4
`define BVS_CODE_LSB 0
`define BVS_RO_MSB 13
`define BVS_RO_LSB 5
`define BVS_SPARE_MSB 15
`define BVS_SPARE_LSB 14
// mask of the read-only zero bits 13:5
`define BVS_RO_MASK 16'h3FE0
// mask of the writable bits
`define BVS_RW_MASK 16'hC01F
// value held before the backup copy is loaded
`define BVS_RESET_VALUE 16'h0000
// reference table entry width, in units of 1/1024 V
`define BVS_REF_WIDTH 10
// soft-start slew step period in cycles
`define BVS_SLEW_CYCLES 8'h10
`endif

// *** hdl/bvs_ref_table.v ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// boot code to reference voltage lookup
// ----------------------------------------
// output in 1/1024 V steps, rounded to the nearest step
module bvs_ref_table
(
    // code in
    input wire [4:0] bootCode,
    // reference out
    output reg [9:0] refLevel
);

    // constant table; monotonic rising
    always @*
    begin
        case (bootCode)
            5'h00: refLevel = 10'h000;
            5'h01: refLevel = 10'h133;
            5'h02: refLevel = 10'h140;
            5'h03: refLevel = 10'h14D;
            5'h04: refLevel = 10'h15A;
            5'h05: refLevel = 10'h167;
            5'h06: refLevel = 10'h173;
            5'h07: refLevel = 10'h180;
            5'h08: refLevel = 10'h18D;
            5'h09: refLevel = 10'h199;
            5'h0A: refLevel = 10'h1A6;
            5'h0B: refLevel = 10'h1B3;
            5'h0C: refLevel = 10'h1C0;
            5'h0D: refLevel = 10'h1CD;
            5'h0E: refLevel = 10'h1DA;
            5'h0F: refLevel = 10'h1E7;
            5'h10: refLevel = 10'h1F3;
            5'h11: refLevel = 10'h200;
            5'h12: refLevel = 10'h20D;
            5'h13: refLevel = 10'h219;
            5'h14: refLevel = 10'h226;
            5'h15: refLevel = 10'h233;
            5'h16: refLevel = 10'h240;
            5'h17: refLevel = 10'h24D;
            5'h18: refLevel = 10'h25A;
            5'h19: refLevel = 10'h266;
            5'h1A: refLevel = 10'h280;
            5'h1B: refLevel = 10'h299;
            5'h1C: refLevel = 10'h2B3;
            5'h1D: refLevel = 10'h2CD;
            5'h1E: refLevel = 10'h2E6;
            default: refLevel = 10'h300;
        endcase
    end

endmodule // bvs_ref_table
`default_nettype wire

// *** hdl/bvs_boot_voltage_select.v ***
// Functional notes
// (R1) Register sits at command D5h, word read and write, unsigned value.
// (R2) Backup copy kept in nonvolatile store; writes act at once.
// (R3) Bits 13:5 are read-only and always read zero.
// (R4) Bits 4:0 give the reference DAC target code for soft-start.
// (R5) Host picks output scale factor to reach the wanted voltage; the code divides by that factor with bit 0 forced to one.
// (R6) Effective boot voltage combines code, scale, margins and trim.
// (R7) Boot code writes accepted in every operating state; writes before the backup load get neither ack nor NACK.
// (R8) Code change during soft-start slews target to the new setting.
// (R9) Write touching bits 13:5 is NACKed and discarded.
// (R10) Invalid write sets summary comm fault and invalid-data status bits.
// (R11) Code maps monotonically to 0 V .. 0.75 V reference levels.
// (R12) Bits 15:14 are spare stored bits with no function.
// (R13) Backup loaded at power-up before reads are answered.
`timescale 1ns/1ns
`default_nettype none
`include "bvs_defs.vh"
module bvs_boot_voltage_select
(
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // command port from the bus interface logic
    input wire [7:0] cmdCode,
    input wire wrStrobe,
    input wire [15:0] wrData,
    input wire rdStrobe,
    output reg [15:0] rdData,
    output reg rdValid,
    output wire rdBusy,
    output reg wrAck,
    output reg wrNack,
    // fault status pulses to the status registers
    output reg commFaultSet,
    output reg invalidDataSet,
    // backup store interface
    input wire nvmLoadValid,
    input wire [15:0] nvmLoadData,
    output reg nvmSaveReq,
    output reg [15:0] nvmSaveData,
    // regulator state and output settings
    input wire softStartActive,
    input wire [15:0] outputScaleFactor,
    input wire [15:0] upperMarginSetting,
    input wire [15:0] lowerMarginSetting,
    input wire [15:0] outputFineAdjust,
    input wire marginHigh,
    input wire marginLow,
    // reference outputs
    output reg [4:0] bootCodeField,
    output reg [1:0] spareStoredBits,
    output wire [9:0] bootReferenceVoltage,
    output reg [9:0] dacTarget,
    output reg [31:0] effectiveBoot
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    reg loaded;
    wire hit;
    wire roTouched;
    wire [9:0] refLevel;
    reg [9:0] refHold;
    reg [7:0] slewCount;
    reg [15:0] adjWord;

    // (R1) command decode
    assign hit = (cmdCode == `BVS_CMD_CODE);
    // (R9) read-only bits nonzero
    assign roTouched = |(wrData & `BVS_RO_MASK);
    // reads wait until the backup has been loaded
    assign rdBusy = hit & rdStrobe & ~loaded;
    assign bootReferenceVoltage = refHold;

    // (R11) code to level lookup
    bvs_ref_table uTable
    (
        .bootCode(bootCodeField),
        .refLevel(refLevel)
    );

    // level output from a flop; trades one cycle of lag for a glitch-free data output
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            refHold <= 10'h000;
        end
        else
        begin
            refHold <= refLevel;
        end
    end

    // ----------------------------------------
    // register and backup
    // ----------------------------------------
    // (R13) load backup before serving; (R2) writes act at once
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            loaded <= 1'b0;
            bootCodeField <= 5'h00;
            spareStoredBits <= 2'h0;
            wrAck <= 1'b0;
            wrNack <= 1'b0;
            commFaultSet <= 1'b0;
            invalidDataSet <= 1'b0;
            nvmSaveReq <= 1'b0;
            nvmSaveData <= `BVS_RESET_VALUE;
        end
        else
        begin
            wrAck <= 1'b0;
            wrNack <= 1'b0;
            commFaultSet <= 1'b0;
            invalidDataSet <= 1'b0;
            nvmSaveReq <= 1'b0;
            if (!loaded)
            begin
                if (nvmLoadValid)
                begin
                    loaded <= 1'b1;
                    bootCodeField <= nvmLoadData[`BVS_CODE_MSB:`BVS_CODE_LSB];
                    spareStoredBits <= nvmLoadData[`BVS_SPARE_MSB:`BVS_SPARE_LSB];
                end
            end
            else if (hit && wrStrobe)
            begin
                // (R9) reject and discard
                if (roTouched)
                begin
                    wrNack <= 1'b1;
                    // (R10) flag status bits
                    commFaultSet <= 1'b1;
                    invalidDataSet <= 1'b1;
                end
                // (R7) no soft-start gating on writes; writes before the backup load are dropped
                else
                begin
                    wrAck <= 1'b1;
                    bootCodeField <= wrData[`BVS_CODE_MSB:`BVS_CODE_LSB];
                    // (R12) spare bits stored only
                    spareStoredBits <= wrData[`BVS_SPARE_MSB:`BVS_SPARE_LSB];
                    // (R2) mirror to backup
                    nvmSaveReq <= 1'b1;
                    nvmSaveData <= wrData & `BVS_RW_MASK;
                end
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // (R3) bits 13:5 forced to zero
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdData <= 16'h0000;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= hit & rdStrobe & loaded;
            if (hit && rdStrobe && loaded)
            begin
                rdData <= {spareStoredBits, 9'h000, bootCodeField};
            end
        end
    end

    // ----------------------------------------
    // soft-start target slew
    // ----------------------------------------
    // (R4) target follows code; (R8) slew one step per period in soft-start
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            dacTarget <= 10'h000;
            slewCount <= 8'h00;
        end
        else if (!softStartActive)
        begin
            dacTarget <= refLevel;
            slewCount <= 8'h00;
        end
        else if (slewCount != 8'h00)
        begin
            slewCount <= slewCount - 8'h01;
        end
        else if (dacTarget != refLevel)
        begin
            // small steps keep the output ramp free of jumps
            slewCount <= `BVS_SLEW_CYCLES - 8'h01;
            if (dacTarget < refLevel)
            begin
                dacTarget <= dacTarget + 10'h001;
            end
            else
            begin
                dacTarget <= dacTarget - 10'h001;
            end
        end
    end

    // ----------------------------------------
    // effective boot voltage
    // ----------------------------------------
    // margin select; high wins if both asserted
    always @*
    begin
        if (marginHigh)
        begin
            adjWord = upperMarginSetting;
        end
        else if (marginLow)
        begin
            adjWord = lowerMarginSetting;
        end
        else
        begin
            adjWord = outputFineAdjust;
        end
    end

    // (R6) combine code, scale, margin and trim; (R5) host scale used with bit 0 forced to one
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            effectiveBoot <= 32'h00000000;
        end
        else
        begin
            effectiveBoot <= {6'h00, dacTarget, 16'h0000} / {16'h0000, outputScaleFactor | 16'h0001}
                + {16'h0000, adjWord};
        end
    end

endmodule // bvs_boot_voltage_select
`default_nettype wire

// *** tb/bvs_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host side of the command port
// ----------------------------------------
module bvs_host_model
(
    // clock
    input wire logic sys_clk,
    // command port
    output logic [7:0] cmdCode,
    output logic wrStrobe,
    output logic [15:0] wrData,
    output logic rdStrobe,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic rdBusy,
    input wire logic wrAck,
    input wire logic wrNack
);
    initial
    begin
        cmdCode = 8'h00;
        wrStrobe = 1'b0;
        wrData = 16'h0000;
        rdStrobe = 1'b0;
    end
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic [1:0] ans);
        @(posedge sys_clk);
        #1;
        cmdCode = cmd;
        wrData = d;
        wrStrobe = 1'b1;
        @(posedge sys_clk);
        #1;
        wrStrobe = 1'b0;
        wrData = ~d; // released data is not a stale copy
        ans = {wrNack, wrAck};
    endtask
    // word read, answer one edge later
    task automatic rd_word(output logic [15:0] d, output logic ok, output logic busy);
        @(posedge sys_clk);
        #1;
        cmdCode = 8'hD5;
        rdStrobe = 1'b1;
        #1;
        busy = rdBusy;
        @(posedge sys_clk);
        #1;
        rdStrobe = 1'b0;
        d = rdData;
        ok = rdValid;
    endtask
endmodule // bvs_host_model
`default_nettype wire

// *** tb/bvs_checker_props.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bvs_defs.vh"
module bvs_checker
(
    input wire sys_clk,
    input wire srst,
    input wire [7:0] cmdCode,
    input wire wrStrobe,
    input wire [15:0] wrData,
    input wire rdStrobe,
    input wire [15:0] rdData,
    input wire rdValid,
    input wire rdBusy,
    input wire wrAck,
    input wire wrNack,
    input wire commFaultSet,
    input wire invalidDataSet,
    input wire nvmLoadValid,
    input wire nvmSaveReq,
    input wire [15:0] nvmSaveData,
    input wire [4:0] bootCodeField,
    input wire [1:0] spareStoredBits
);
    logic loaded;
    wire hit = cmdCode == `BVS_CMD_CODE;
    wire bad = |(wrData & `BVS_RO_MASK);
    wire goodWr = loaded && hit && wrStrobe && !bad;
    wire badWr = loaded && hit && wrStrobe && bad;
    // backup seen since reset
    always @(posedge sys_clk)
        loaded <= srst ? 1'b0 : (loaded | nvmLoadValid);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wr_ack_a: assert property (goodWr |=> wrAck && !wrNack) else $error("no ack");
    wr_nack_a: assert property (badWr |=> wrNack && !wrAck) else $error("no nack");
    fault_flags_a: assert property (badWr |=> commFaultSet && invalidDataSet)
        else $error("no fault flags");
    nack_keep_a: assert property (badWr |=> $stable(bootCodeField) && !nvmSaveReq)
        else $error("nack changed value");
    code_update_a: assert property (goodWr |=> bootCodeField == $past(wrData[4:0])
        && spareStoredBits == $past(wrData[15:14])) else $error("code not updated");
    save_copy_a: assert property (goodWr |=> nvmSaveReq
        && nvmSaveData == ($past(wrData) & `BVS_RW_MASK)) else $error("bad save");
    read_zero_a: assert property (rdValid |-> rdData[13:5] == 9'h000)
        else $error("ro bits set");
    read_ans_a: assert property (loaded && hit && rdStrobe |=> rdValid) else $error("no read");
    load_busy_a: assert property (!loaded && hit && rdStrobe |-> rdBusy ##1 !rdValid)
        else $error("read before load");
    cover property (goodWr);
    cover property (badWr);
    cover property (rdValid);
    cover property (rdBusy);
endmodule // bvs_checker
bind bvs_boot_voltage_select bvs_checker chk (.sys_clk, .srst, .cmdCode, .wrStrobe, .wrData,
    .rdStrobe, .rdData, .rdValid, .rdBusy, .wrAck, .wrNack, .commFaultSet, .invalidDataSet,
    .nvmLoadValid, .nvmSaveReq, .nvmSaveData, .bootCodeField, .spareStoredBits);
`default_nettype wire

// *** tb/bvs_boot_voltage_select_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module bvs_boot_voltage_select_tb_top;
    logic sys_clk = 1'b0, srst = 1'b1, nvmLoadValid = 1'b0, softStartActive = 1'b0;
    logic [15:0] nvmLoadData = 16'h8002, scale = 16'h0100, up = 16'h0, lo = 16'h0, adj = 16'h0;
    logic mHi = 1'b0, mLo = 1'b0, rdValid, rdBusy, wrAck, wrNack, ok, busy, wrStrobe, rdStrobe;
    logic [7:0] cmdCode;
    logic [15:0] wrData, rdData, got, exp, wd;
    logic [31:0] eff;
    logic [4:0] code;
    logic [9:0] refV, dac, dac0;
    logic [1:0] ans;
    logic [31:0] rnd = 32'h00017DD7;
    int failCount = 0, totalChecks = 0, cyc = 0;
    initial forever #4 sys_clk = ~sys_clk;
    bvs_host_model host (.sys_clk, .cmdCode, .wrStrobe, .wrData, .rdStrobe, .rdData,
        .rdValid, .rdBusy, .wrAck, .wrNack);
    bvs_boot_voltage_select uut (.sys_clk, .srst, .cmdCode, .wrStrobe, .wrData, .rdStrobe,
        .rdData, .rdValid, .rdBusy, .wrAck, .wrNack, .commFaultSet(), .invalidDataSet(),
        .nvmLoadValid, .nvmLoadData, .nvmSaveReq(), .nvmSaveData(), .softStartActive,
        .outputScaleFactor(scale), .upperMarginSetting(up), .lowerMarginSetting(lo),
        .outputFineAdjust(adj), .marginHigh(mHi), .marginLow(mLo), .bootCodeField(code),
        .spareStoredBits(), .bootReferenceVoltage(refV), .dacTarget(dac), .effectiveBoot(eff));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected reference levels of a few codes, 1/1024 V
    function automatic logic [9:0] ref_of(input int i);
        return i == 0 ? 10'h000 : i == 1 ? 10'h140 : i == 2 ? 10'h200 :
            i == 3 ? 10'h133 : i == 4 ? 10'h219 : 10'h300;
    endfunction
    // codes of the table check; the last one leaves 1Fh in the register
    function automatic logic [4:0] code_of(input int i);
        return i == 0 ? 5'h00 : i == 1 ? 5'h02 : i == 2 ? 5'h11 :
            i == 3 ? 5'h01 : i == 4 ? 5'h13 : 5'h1F;
    endfunction
    task automatic check(input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e)
        begin
            failCount++;
            $display("wrong value at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // cycle ceiling cuts a hang short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failCount++;
            final_report();
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1 srst = 1'b0;
        host.wr_word(8'hD5, 16'h0011, ans);
        check(16'h0, ans);
        host.rd_word(got, ok, busy);
        check(16'h1, {ok, busy});
        @(posedge sys_clk);
        #1 nvmLoadValid = 1'b1;
        @(posedge sys_clk);
        #1 nvmLoadValid = 1'b0;
        host.rd_word(got, ok, busy);
        check(16'h8002, got);
        $display("load test done");
        for (int i = 0; i < 6; i++)
        begin
            host.wr_word(8'hD5, {11'h000, code_of(i)}, ans);
            // level output is a flop, one edge behind the code
            @(posedge sys_clk);
            #1;
            check(ref_of(i), refV);
        end
        host.wr_word(8'hD4, 16'h0005, ans);
        check({2'h0, 5'h1F}, {ans, code});
        // random words, ro bits set in about half
        exp = 16'h001F;
        for (int i = 0; i < 60; i++)
        begin
            rnd = lfsr(rnd);
            {softStartActive, mHi, mLo} = rnd[31:29];
            // host picks the scale beside the code
            {scale, up, lo, adj} = {rnd, ~rnd};
            wd = rnd[16] ? rnd[15:0] : rnd[15:0] & 16'hC01F;
            host.wr_word(8'hD5, wd, ans);
            if ((wd & 16'h3FE0) == 16'h0)
                exp = wd;
            check({wd & 16'h3FE0 ? 2'h2 : 2'h1}, ans);
            host.rd_word(got, ok, busy);
            check(exp, got);
        end
        $display("random test done");
        softStartActive = 1'b0;
        host.wr_word(8'hD5, 16'h0000, ans);
        @(posedge sys_clk);
        #1 softStartActive = 1'b1;
        dac0 = dac;
        host.wr_word(8'hD5, 16'h001F, ans);
        repeat (64) @(posedge sys_clk);
        #1;
        check(16'h1, dac > dac0 && dac < 10'h300);
        softStartActive = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(16'h0300, dac);
        $display("slew test done");
        // trim, then low margin, then high margin over low
        scale = 16'h0001;
        adj = 16'h0005;
        {mHi, mLo} = 2'h0;
        @(posedge sys_clk);
        #1;
        check(32'h03000005, eff);
        scale = 16'h0002;
        lo = 16'h0009;
        mLo = 1'b1;
        @(posedge sys_clk);
        #1;
        check(32'h01000009, eff);
        up = 16'h0007;
        mHi = 1'b1;
        @(posedge sys_clk);
        #1;
        check(32'h01000007, eff);
        $display("margin test done");
        final_report();
    end
endmodule // bvs_boot_voltage_select_tb_top
`default_nettype wire
